// [rtl/rtc_sram_core.sv]
// Byte-wide storage with clock registers at the top eight locations
//
// Functional notes
// R01: Supply fail blocks writes, outputs, inputs
// R02: Protection holds for recovery time after return
// R03: Host keeps chip deselected during power-up
// R04: Read bit freezes user register updates
// R05: Frozen registers hold; counters keep counting
// R06: All registers load together, update not cut
// R07: Updates resume within one second after clear
// R08: Write bit also freezes register updates
// R09: Clearing write bit loads counters, restarts
// R10: Host writes 24-hour BCD, zeros in fixed bits
// R11: Seconds MSB halts or runs oscillator
// R12: Halt bit set at reset; runs within second
// R13: 32768 Hz base, correction at divide-by-256
// R14: Five-bit magnitude, D5 sign speeds up
// R15: 64-minute cycle, shorten 128 or lengthen 256
// R16: Magnitude N adjusts first 2N minutes
// R17: Probe toggles 512 Hz when enabled, running
// R18: Century flag toggles at rollover if enabled
// R19: Century enable writable any time
// R20: Century flag writable only with write bit
// R21: Low cell flag read-only, enable writable
// R22: Power-up check sets flag if enabled, low
// R23: Top eight addresses reach clock registers
`timescale 1ns/100ps
`include "rtc_core_defines.svh"
`default_nettype none
module rtc_sram_core
   import rtc_core_pkg::*;
#(
   parameter int unsigned OSC_HZ = `RTC_OSC_HZ,
   parameter int unsigned CLK_HZ = `RTC_CLK_HZ,
   parameter int unsigned REC_CYC = `RTC_REC_CYC
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Memory bus pins
   input wire logic [12:0] ADDR,
   input wire logic [7:0] DQ_IN,
   output logic [7:0] DQ_OUT,
   output logic DQ_OE,
   input wire logic CHIP_SELECT_LOW_N,
   input wire logic CHIP_SELECT_HIGH,
   input wire logic WRITE_N,
   input wire logic OUTPUT_EN_N,
   // Supply and cell status
   input wire logic SUPPLY_FAIL,
   input wire logic BATTERY_LOW,
   // Frequency probe, open drain
   output logic FREQ_PROBE_O,
   output logic FREQ_PROBE_OE
);
   logic [26:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
   addr_t addr_s, wa_reg;
   logic [7:0] din_s, wd_reg, mux_rd;
   logic csl_n, csh, we_n, oe_n, fail_s, batt_s;
   logic [15:0] rec_cnt_reg;
   logic block, sel, commit, clk_sel, load_ctr, hold, upd;
   access_e acc_reg, acc_next;
   logic [7:0] mem [0:8191];
   logic ctl_write_reg, ctl_read_reg, cal_sign_reg, osc_halt_reg, probe_en_reg, cen_en_reg;
   logic low_en_reg, low_flag_reg;
   logic [4:0] cal_mag_reg;
   logic [6:0] u_sec_reg, u_min_reg, c_sec_reg, c_min_reg;
   logic [5:0] u_hr_reg, u_date_reg, c_hr_reg, c_date_reg, cal_min_reg, dim;
   logic [2:0] u_day_reg, c_day_reg;
   logic [4:0] u_mon_reg, c_mon_reg;
   logic [7:0] u_yr_reg, c_yr_reg;
   logic u_cen_reg, c_cen_reg, leap;
   logic [27:0] phase_reg, phase_sum;
   logic osc_tick_reg, sec_tick, tick_q_reg, adj_min;
   logic [16:0] presc_reg, period;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   // Pins settle through three stages; a bit moves only when the last two stages agree
   assign pin_raw = {ADDR, DQ_IN, CHIP_SELECT_LOW_N, CHIP_SELECT_HIGH, WRITE_N, OUTPUT_EN_N, SUPPLY_FAIL, BATTERY_LOW};
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         s1_reg <= `RTC_PIN_RST;
         s2_reg <= `RTC_PIN_RST;
         s3_reg <= `RTC_PIN_RST;
         pin_reg <= `RTC_PIN_RST;
      end
      else
      begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
      end
   end
   assign addr_s = pin_reg[26:14];
   assign din_s = pin_reg[13:6];
   assign csl_n = pin_reg[5];
   assign csh = pin_reg[4];
   assign we_n = pin_reg[3];
   assign oe_n = pin_reg[2];
   assign fail_s = pin_reg[1];
   assign batt_s = pin_reg[0];

   // Supply guard; fail is assumed until the pin says otherwise
   always_ff @(posedge CORE_CLK)
   begin
      if (RST || fail_s)
         rec_cnt_reg <= 16'(REC_CYC); // R01 R02
      else if (rec_cnt_reg != 16'h0000)
         rec_cnt_reg <= rec_cnt_reg - 16'h0001; // R02
   end
   assign block = fail_s || (rec_cnt_reg != 16'h0000); // R01 R02

   // Cell check runs as protection lifts after each supply return
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         low_flag_reg <= 1'b0;
      else if (rec_cnt_reg == 16'h0001 && !fail_s)
         low_flag_reg <= batt_s ? (low_flag_reg | low_en_reg) : 1'b0; // R22
   end

   // Bus access phases; any input is ignored while blocked
   assign sel = !csl_n && csh && !block; // R01
   always_comb
   begin
      acc_next = ACC_IDLE;
      if (sel && !we_n)
         acc_next = ACC_WRITE;
      else if (sel && !oe_n)
         acc_next = ACC_READ;
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         acc_reg <= ACC_IDLE;
         wa_reg <= 13'h0000;
         wd_reg <= 8'h00;
      end
      else
      begin
         acc_reg <= acc_next;
         if (acc_next == ACC_WRITE)
         begin
            wa_reg <= addr_s;
            wd_reg <= din_s;
         end
      end
   end
   // Write lands at its trailing edge, with the data seen last
   assign commit = (acc_reg == ACC_WRITE) && (acc_next != ACC_WRITE) && !block; // R01
   assign clk_sel = (wa_reg >= `RTC_CTRL_ADDR); // R23

   always_ff @(posedge CORE_CLK)
   begin
      if (commit && !clk_sel)
         mem[wa_reg] <= wd_reg; // R23
   end

   always_comb
   begin
      case (addr_s)
         `RTC_CTRL_ADDR: mux_rd = {ctl_write_reg, ctl_read_reg, cal_sign_reg, cal_mag_reg};
         `RTC_SEC_ADDR: mux_rd = {osc_halt_reg, u_sec_reg};
         `RTC_MIN_ADDR: mux_rd = {1'b0, u_min_reg};
         `RTC_HOUR_ADDR: mux_rd = {2'b00, u_hr_reg};
         `RTC_WDAY_ADDR: mux_rd = {1'b0, probe_en_reg, cen_en_reg, u_cen_reg, 1'b0, u_day_reg};
         `RTC_DATE_ADDR: mux_rd = {low_en_reg, low_flag_reg, u_date_reg}; // R21
         `RTC_MON_ADDR: mux_rd = {3'b000, u_mon_reg};
         `RTC_YEAR_ADDR: mux_rd = u_yr_reg;
         default: mux_rd = mem[addr_s]; // R23
      endcase
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         DQ_OUT <= 8'h00;
         DQ_OE <= 1'b0;
      end
      else
      begin
         DQ_OUT <= mux_rd;
         DQ_OE <= (acc_next == ACC_READ); // R01
      end
   end

   // Control and configuration bits
   assign load_ctr = commit && wa_reg == `RTC_CTRL_ADDR && ctl_write_reg && !wd_reg[`RTC_CTL_WRITE_BIT]; // R09
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ctl_write_reg <= 1'b0;
         ctl_read_reg <= 1'b0;
         cal_sign_reg <= 1'b0;
         cal_mag_reg <= 5'h00;
         osc_halt_reg <= `RTC_HALT_RST; // R12
         probe_en_reg <= 1'b0;
         cen_en_reg <= 1'b0;
         low_en_reg <= 1'b0;
      end
      else if (commit)
      begin
         case (wa_reg)
            `RTC_CTRL_ADDR:
            begin
               ctl_write_reg <= wd_reg[`RTC_CTL_WRITE_BIT]; // R08
               ctl_read_reg <= wd_reg[`RTC_CTL_READ_BIT]; // R04
               cal_sign_reg <= wd_reg[`RTC_CTL_SIGN_BIT]; // R14
               cal_mag_reg <= wd_reg[4:0]; // R14
            end
            `RTC_SEC_ADDR: osc_halt_reg <= wd_reg[`RTC_SEC_HALT_BIT]; // R11
            `RTC_WDAY_ADDR:
            begin
               probe_en_reg <= wd_reg[`RTC_DAY_PROBE_BIT];
               cen_en_reg <= wd_reg[`RTC_DAY_CEN_EN_BIT]; // R19
            end
            `RTC_DATE_ADDR: low_en_reg <= wd_reg[`RTC_DATE_LOWEN_BIT]; // R21
            default: ;
         endcase
      end
   end

   // User time registers, loaded from the counters once a second
   assign hold = ctl_write_reg || ctl_read_reg; // R04 R08
   assign upd = tick_q_reg && !hold; // R05 R07
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         u_sec_reg <= 7'h00;
         u_min_reg <= 7'h00;
         u_hr_reg <= 6'h00;
         u_day_reg <= `RTC_DAY_RST;
         u_cen_reg <= 1'b0;
         u_date_reg <= `RTC_DATE_RST;
         u_mon_reg <= `RTC_MON_RST;
         u_yr_reg <= 8'h00;
      end
      else
      begin
         if (upd)
         begin
            u_sec_reg <= c_sec_reg; // R06
            u_min_reg <= c_min_reg;
            u_hr_reg <= c_hr_reg;
            u_day_reg <= c_day_reg;
            u_cen_reg <= c_cen_reg;
            u_date_reg <= c_date_reg;
            u_mon_reg <= c_mon_reg;
            u_yr_reg <= c_yr_reg;
         end
         if (commit)
         begin
            case (wa_reg)
               `RTC_SEC_ADDR: u_sec_reg <= wd_reg[6:0];
               `RTC_MIN_ADDR: u_min_reg <= wd_reg[6:0];
               `RTC_HOUR_ADDR: u_hr_reg <= wd_reg[5:0];
               `RTC_WDAY_ADDR:
               begin
                  u_day_reg <= wd_reg[2:0];
                  if (ctl_write_reg)
                     u_cen_reg <= wd_reg[`RTC_DAY_CEN_BIT]; // R20
               end
               `RTC_DATE_ADDR: u_date_reg <= wd_reg[5:0];
               `RTC_MON_ADDR: u_mon_reg <= wd_reg[4:0];
               `RTC_YEAR_ADDR: u_yr_reg <= wd_reg;
               default: ;
            endcase
         end
      end
   end

   // Oscillator rate from the core clock by fractional accumulation
   // Remainder carried over so the long-term rate stays exact for any core clock not slower than the oscillator
   assign phase_sum = phase_reg + 28'(OSC_HZ);
   always_ff @(posedge CORE_CLK)
   begin
      if (RST || osc_halt_reg)
      begin
         phase_reg <= 28'h0000000; // R11
         osc_tick_reg <= 1'b0; // R11
      end
      else
      begin
         osc_tick_reg <= (phase_sum >= 28'(CLK_HZ)); // R12 R13
         phase_reg <= (phase_sum >= 28'(CLK_HZ)) ? phase_sum - 28'(CLK_HZ) : phase_sum;
      end
   end

   // Correction: first second of each early minute in the cycle
   assign adj_min = (cal_min_reg < {cal_mag_reg, 1'b0}) && (c_sec_reg == 7'h00); // R16
   assign period = !adj_min ? `RTC_SEC_PERIOD : cal_sign_reg ? `RTC_SEC_PERIOD - `RTC_CAL_SHORTEN :
                   `RTC_SEC_PERIOD + `RTC_CAL_LENGTHEN; // R13 R14 R15
   assign sec_tick = osc_tick_reg && (presc_reg == period - 17'h00001);
   always_ff @(posedge CORE_CLK)
   begin
      if (RST || load_ctr)
         presc_reg <= 17'h00000; // R09
      else if (osc_tick_reg)
         presc_reg <= sec_tick ? 17'h00000 : presc_reg + 17'h00001;
   end
   // Probe pulls low on half periods; stopped oscillator leaves it released
   assign FREQ_PROBE_O = 1'b0;
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         FREQ_PROBE_OE <= 1'b0;
      else
         FREQ_PROBE_OE <= probe_en_reg && !osc_halt_reg && !presc_reg[`RTC_PROBE_BIT]; // R17
   end

   // Leap years in BCD: even tens with 0,4,8 or odd tens with 2,6
   assign leap = c_yr_reg[4] ? (c_yr_reg[3:0] == 4'h2 || c_yr_reg[3:0] == 4'h6) : (c_yr_reg[1:0] == 2'b00);
   assign dim = (c_mon_reg == 5'h02) ? (leap ? 6'h29 : 6'h28) :
                (c_mon_reg == 5'h04 || c_mon_reg == 5'h06 || c_mon_reg == 5'h09 || c_mon_reg == 5'h11) ? 6'h30 : 6'h31;

   // Clock counters never pause for a held view
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         c_sec_reg <= 7'h00;
         c_min_reg <= 7'h00;
         c_hr_reg <= 6'h00;
         c_day_reg <= `RTC_DAY_RST;
         c_cen_reg <= 1'b0;
         c_date_reg <= `RTC_DATE_RST;
         c_mon_reg <= `RTC_MON_RST;
         c_yr_reg <= 8'h00;
         cal_min_reg <= 6'h00;
         tick_q_reg <= 1'b0;
      end
      else
      begin
         tick_q_reg <= sec_tick && !load_ctr;
         if (load_ctr)
         begin
            c_sec_reg <= u_sec_reg; // R09
            c_min_reg <= u_min_reg;
            c_hr_reg <= u_hr_reg;
            c_day_reg <= u_day_reg;
            c_cen_reg <= u_cen_reg;
            c_date_reg <= u_date_reg;
            c_mon_reg <= u_mon_reg;
            c_yr_reg <= u_yr_reg;
         end
         else if (sec_tick)
         begin
            c_sec_reg <= (c_sec_reg == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, c_sec_reg})); // R05
            if (c_sec_reg == 7'h59)
            begin
               cal_min_reg <= cal_min_reg + 6'h01; // R15
               c_min_reg <= (c_min_reg == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, c_min_reg}));
               if (c_min_reg == 7'h59)
               begin
                  c_hr_reg <= (c_hr_reg == 6'h23) ? 6'h00 : 6'(bcd_inc({2'b00, c_hr_reg}));
                  if (c_hr_reg == 6'h23)
                  begin
                     c_day_reg <= (c_day_reg == 3'h7) ? 3'h1 : c_day_reg + 3'h1;
                     c_date_reg <= (c_date_reg == dim) ? 6'h01 : 6'(bcd_inc({2'b00, c_date_reg}));
                     if (c_date_reg == dim)
                     begin
                        c_mon_reg <= (c_mon_reg == 5'h12) ? 5'h01 : 5'(bcd_inc({3'b000, c_mon_reg}));
                        if (c_mon_reg == 5'h12)
                        begin
                           c_yr_reg <= (c_yr_reg == 8'h99) ? 8'h00 : bcd_inc(c_yr_reg);
                           if (c_yr_reg == 8'h99 && cen_en_reg)
                              c_cen_reg <= !c_cen_reg; // R18
                        end
                     end
                  end
               end
            end
         end
      end
   end

   property p_fail_quiet;
      @(posedge CORE_CLK) disable iff (RST) fail_s |=> !DQ_OE && !commit;
   endproperty
   a_fail_quiet: assert property (p_fail_quiet) else $error("Outputs or writes active in supply fail"); // R01
   property p_recovery;
      @(posedge CORE_CLK) disable iff (RST) $fell(fail_s) |-> block [*8];
   endproperty
   a_recovery: assert property (p_recovery) else $error("Protection lifted early after supply return"); // R02
   property p_read_hold;
      @(posedge CORE_CLK) disable iff (RST) ctl_read_reg && $past(ctl_read_reg) && !$past(commit) |-> $stable(u_sec_reg);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("Seconds changed while read hold set"); // R04
   property p_count_on;
      @(posedge CORE_CLK) disable iff (RST) hold && sec_tick && !load_ctr |=> c_sec_reg != $past(c_sec_reg);
   endproperty
   a_count_on: assert property (p_count_on) else $error("Counters stalled during hold"); // R05
   property p_write_hold;
      @(posedge CORE_CLK) disable iff (RST) ctl_write_reg && $past(ctl_write_reg) && !$past(commit) |-> $stable(u_min_reg);
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("Minutes changed while set bit held"); // R08
   property p_load;
      @(posedge CORE_CLK) disable iff (RST) load_ctr |=> c_sec_reg == $past(u_sec_reg) && presc_reg == 17'h00000;
   endproperty
   a_load: assert property (p_load) else $error("Counters not loaded on set bit clear"); // R09
   property p_halt;
      @(posedge CORE_CLK) disable iff (RST) osc_halt_reg |=> !osc_tick_reg;
   endproperty
   a_halt: assert property (p_halt) else $error("Oscillator ticked while halted"); // R11
   property p_plain_second;
      @(posedge CORE_CLK) disable iff (RST) sec_tick && cal_mag_reg == 5'h00 |-> presc_reg == 17'h07FFF;
   endproperty
   a_plain_second: assert property (p_plain_second) else $error("Uncalibrated second not 32768 ticks"); // R16
   property p_probe_off;
      @(posedge CORE_CLK) disable iff (RST) !probe_en_reg || osc_halt_reg |=> !FREQ_PROBE_OE;
   endproperty
   a_probe_off: assert property (p_probe_off) else $error("Probe driven while disabled"); // R17
   property p_century;
      @(posedge CORE_CLK) disable iff (RST) !cen_en_reg && !load_ctr |=> $stable(c_cen_reg);
   endproperty
   a_century: assert property (p_century) else $error("Century flag moved while disabled"); // R18
endmodule : rtc_sram_core
`default_nettype wire

// [rtl/rtc_core_defines.svh]
// Offsets, field positions, reset values and timing counts of the clock core
`ifndef RTC_CORE_DEFINES_SVH
`define RTC_CORE_DEFINES_SVH
`define RTC_CTRL_ADDR 13'h1FF8
`define RTC_SEC_ADDR 13'h1FF9
`define RTC_MIN_ADDR 13'h1FFA
`define RTC_HOUR_ADDR 13'h1FFB
`define RTC_WDAY_ADDR 13'h1FFC
`define RTC_DATE_ADDR 13'h1FFD
`define RTC_MON_ADDR 13'h1FFE
`define RTC_YEAR_ADDR 13'h1FFF
`define RTC_CTL_WRITE_BIT 7
`define RTC_CTL_READ_BIT 6
`define RTC_CTL_SIGN_BIT 5
`define RTC_SEC_HALT_BIT 7
`define RTC_DAY_PROBE_BIT 6
`define RTC_DAY_CEN_EN_BIT 5
`define RTC_DAY_CEN_BIT 4
`define RTC_DATE_LOWEN_BIT 7
`define RTC_DATE_LOWFLAG_BIT 6
`define RTC_HALT_RST 1'b1
`define RTC_DAY_RST 3'h1
`define RTC_DATE_RST 6'h01
`define RTC_MON_RST 5'h01
`define RTC_PIN_RST 27'h000002E
`define RTC_OSC_HZ 32768
`define RTC_CLK_HZ 250000000
`define RTC_CLK_MHZ 250
`define RTC_SEC_PERIOD 17'h08000
`define RTC_CAL_SHORTEN 17'h00080
`define RTC_CAL_LENGTHEN 17'h00100
`define RTC_PROBE_BIT 5
`define RTC_T_REC_NS 1000
`define RTC_REC_CYC ((`RTC_T_REC_NS * `RTC_CLK_MHZ + 999) / 1000)
`endif

// [rtl/rtc_core_pkg.sv]
// Types shared by the clock register core
package rtc_core_pkg;
   typedef enum {ACC_IDLE, ACC_READ, ACC_WRITE} access_e;
   typedef logic [12:0] addr_t;
endpackage : rtc_core_pkg

// [bench/host_bus_model.sv]
// Host processor model on the byte-wide memory bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
   import rtc_core_pkg::*;
(
   // Clock and answer
   input wire logic core_clk,
   input wire logic dq_oe,
   // Bus pins driven by the host
   output var addr_t addr,
   output logic [7:0] host_dq,
   output logic cs_low_n,
   output logic cs_high,
   output logic write_n,
   output logic out_en_n
);
   // Deselected from time zero so no stray write lands at power-up
   initial
   begin
      addr = 13'h0000;
      host_dq = 8'h00;
      cs_low_n = 1'b1;
      cs_high = 1'b0;
      write_n = 1'b1;
      out_en_n = 1'b1;
   end

   // Released lines show the inverse so stale values never look valid
   task automatic idle_bus();
      cs_low_n = 1'b1;
      cs_high = 1'b0;
      write_n = 1'b1;
      out_en_n = 1'b1;
      addr = ~addr;
      host_dq = ~host_dq;
   endtask : idle_bus

   // Address and data outlast the strobe so the filtered copy is clean
   task automatic write_byte(input addr_t a, input logic [7:0] d);
      @(negedge core_clk);
      addr = a;
      host_dq = d;
      cs_low_n = 1'b0;
      cs_high = 1'b1;
      write_n = 1'b0;
      repeat (8) @(negedge core_clk);
      write_n = 1'b1;
      repeat (6) @(negedge core_clk);
      idle_bus();
      repeat (8) @(negedge core_clk);
   endtask : write_byte

   task automatic read_byte(input addr_t a, output logic seen);
      @(negedge core_clk);
      seen = 1'b0;
      addr = a;
      cs_low_n = 1'b0;
      cs_high = 1'b1;
      out_en_n = 1'b0;
      repeat (8)
      begin
         @(posedge core_clk);
         if (dq_oe === 1'b1)
            seen = 1'b1;
      end
      @(negedge core_clk);
      idle_bus();
      repeat (8) @(negedge core_clk);
   endtask : read_byte
endmodule : host_bus_model
`default_nettype wire

// [bench/test_rtc_sram_core.sv]
// Self-checking bench of the clock register core
`timescale 1ns/100ps
`default_nettype none
`include "rtc_core_defines.svh"
module test_rtc_sram_core;
   import rtc_core_pkg::*;
   // One second is 32768 cycles with oscillator and core clock equal
   localparam int unsigned LIMIT = 110000;
   localparam logic [7:0] RST_VALS [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   localparam logic [7:0] SET_VALS [8] = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h37, 8'h31, 8'h12, 8'h99};
   localparam logic [7:0] ROLL_VALS [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h01, 8'h01, 8'h00};
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic supply_fail = 1'b0;
   logic battery_low = 1'b0;
   addr_t addr;
   logic [7:0] host_dq;
   logic [7:0] dq_wire;
   logic [7:0] dq_out;
   logic dq_oe;
   logic cs_low_n;
   logic cs_high;
   logic write_n;
   logic out_en_n;
   logic probe_o;
   logic probe_oe;
   logic probe_pin;
   logic oe_prev = 1'b0;
   logic seen;
   logic [7:0] exp_q [$];
   logic [7:0] ram_d [3];
   addr_t ram_a [3];
   logic [31:0] seed = 32'h99EF;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   int t0;
   int n;

   always #2 core_clk = ~core_clk;

   // Shared data wire and pulled-up probe pin
   assign dq_wire = dq_oe ? dq_out : host_dq;
   assign probe_pin = probe_oe ? probe_o : 1'b1;

   rtc_sram_core #(.OSC_HZ(32768), .CLK_HZ(32768), .REC_CYC(20)) uut (
      .CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .DQ_IN(dq_wire), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .CHIP_SELECT_LOW_N(cs_low_n), .CHIP_SELECT_HIGH(cs_high), .WRITE_N(write_n),
      .OUTPUT_EN_N(out_en_n), .SUPPLY_FAIL(supply_fail), .BATTERY_LOW(battery_low),
      .FREQ_PROBE_O(probe_o), .FREQ_PROBE_OE(probe_oe));

   host_bus_model host (
      .core_clk(core_clk), .dq_oe(dq_oe), .addr(addr), .host_dq(host_dq), .cs_low_n(cs_low_n),
      .cs_high(cs_high), .write_n(write_n), .out_en_n(out_en_n));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction : xs

   task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
      n_tests++;
      if (seen_v !== exp_v)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
      end
   endtask : check

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // Note the expected byte, then let the host read it
   task automatic read_exp(input addr_t a, input logic [7:0] e);
      exp_q.push_back(e);
      host.read_byte(a, seen);
      if (seen !== 1'b1)
         void'(exp_q.pop_back());
      check({7'h00, seen}, 8'h01);
   endtask : read_exp

   task automatic read_refused(input addr_t a);
      host.read_byte(a, seen);
      check({7'h00, seen}, 8'h00);
   endtask : read_refused

   task automatic wait_to(input int c);
      while (cycles < c)
         @(negedge core_clk);
   endtask : wait_to

   // Half period of the probe pin, 200 when it never moves
   task automatic probe_half(output int h);
      logic start;
      int k;
      start = probe_pin;
      for (k = 0; k < 200 && probe_pin === start; k++)
         @(posedge core_clk);
      start = probe_pin;
      for (h = 0; h < 200 && probe_pin === start; h++)
         @(posedge core_clk);
   endtask : probe_half

   // Result watcher; an empty queue compares against unknown and fails
   always @(posedge core_clk)
   begin
      oe_prev <= dq_oe;
      if (rst === 1'b0 && dq_oe === 1'b1 && oe_prev !== 1'b1)
         check(dq_out, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
   end

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      repeat (40) @(negedge core_clk);
      for (int i = 0; i < 8; i++)
         read_exp(`RTC_CTRL_ADDR + addr_t'(i), RST_VALS[i]);
      // Storage below the clock window, top storage byte included
      for (int i = 0; i < 3; i++)
      begin
         seed = xs(seed);
         ram_a[i] = (i == 0) ? 13'h1FF7 : {1'b0, 2'(i), seed[9:0]};
         ram_d[i] = seed[23:16];
         host.write_byte(ram_a[i], ram_d[i]);
      end
      for (int i = 0; i < 3; i++)
         read_exp(ram_a[i], ram_d[i]);
      read_exp(`RTC_CTRL_ADDR, 8'h00);
      host.write_byte(`RTC_DATE_ADDR, 8'hD5);
      read_exp(`RTC_DATE_ADDR, 8'h95);
      // Supply loss with a low cell, then a good cell
      battery_low = 1'b1;
      supply_fail = 1'b1;
      repeat (10) @(negedge core_clk);
      host.write_byte(ram_a[0], ~ram_d[0]);
      read_refused(`RTC_CTRL_ADDR);
      supply_fail = 1'b0;
      read_refused(`RTC_CTRL_ADDR);
      repeat (40) @(negedge core_clk);
      read_exp(ram_a[0], ram_d[0]);
      read_exp(`RTC_DATE_ADDR, 8'hD5);
      battery_low = 1'b0;
      supply_fail = 1'b1;
      repeat (10) @(negedge core_clk);
      supply_fail = 1'b0;
      repeat (40) @(negedge core_clk);
      read_exp(`RTC_DATE_ADDR, 8'h95);
      // Load the last second of the century and let it roll
      host.write_byte(`RTC_CTRL_ADDR, 8'h80);
      host.write_byte(`RTC_WDAY_ADDR, SET_VALS[4]);
      read_exp(`RTC_WDAY_ADDR, 8'h37);
      for (int i = 1; i < 8; i++)
         host.write_byte(`RTC_CTRL_ADDR + addr_t'(i), SET_VALS[i]);
      host.write_byte(`RTC_CTRL_ADDR, 8'h00);
      t0 = cycles;
      wait_to(t0 + 36000);
      host.write_byte(`RTC_CTRL_ADDR, 8'h40);
      for (int i = 1; i < 8; i++)
         read_exp(`RTC_CTRL_ADDR + addr_t'(i), ROLL_VALS[i]);
      probe_half(n);
      check(8'(n), 8'hC8);
      host.write_byte(`RTC_WDAY_ADDR, 8'h71);
      read_exp(`RTC_WDAY_ADDR, 8'h61);
      probe_half(n);
      check(8'(n), 8'h20);
      // Frozen across the two-second tick, then released
      wait_to(t0 + 68800);
      read_exp(`RTC_SEC_ADDR, 8'h00);
      host.write_byte(`RTC_CTRL_ADDR, 8'h00);
      wait_to(t0 + 98800);
      read_exp(`RTC_SEC_ADDR, 8'h02);
      host.write_byte(`RTC_CTRL_ADDR, 8'h3F);
      read_exp(`RTC_CTRL_ADDR, 8'h3F);
      print_verdict();
   end
endmodule : test_rtc_sram_core
`default_nettype wire
